// [design/qni_pkg.sv]
// constants for the queue notification and interrupt controller
// assumes a device register port with byte offsets in its legacy layout
package qni_pkg;
  // device register offsets
  localparam logic [7:0] DEV_QUEUE_ADDR = 8'h08;
  localparam logic [7:0] DEV_QUEUE_SIZE = 8'h0c;
  localparam logic [7:0] DEV_QUEUE_SEL = 8'h0e;
  localparam logic [7:0] DEV_QUEUE_NOTIFY = 8'h10;
  localparam logic [7:0] DEV_CAUSE = 8'h13;
  localparam logic [7:0] DEV_CFG_VEC = 8'h14;
  localparam logic [7:0] DEV_QUEUE_VEC = 8'h16;
  // vector encodings and queue address shift
  localparam logic [15:0] NO_VECTOR = 16'hffff;
  localparam logic [10:0] TABLE_SIZE_MAX = 11'h7ff;
  localparam int QADDR_SHIFT = 12;
  // cause bits
  localparam int CAUSE_USED = 0;
  localparam int CAUSE_CFG = 1;
  // software register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TABLE = 8'h0c;
  localparam logic [7:0] REG_VEC = 8'h10;
  localparam logic [7:0] REG_QUEUE = 8'h14;
  localparam logic [7:0] REG_QADDR = 8'h18;
  localparam logic [7:0] REG_DOORBELL = 8'h1c;
  localparam logic [7:0] REG_EVENTS = 8'h20;
  localparam logic [7:0] REG_CFGVEC = 8'h24;
  // field positions
  localparam int CTRL_MSG_EN = 0;
  localparam int CTRL_NOTIF_DATA = 1;
  localparam int CMD_MAP_CFG = 0;
  localparam int CMD_QUEUE_CFG = 1;
  localparam int CMD_NOTIFY = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_MAP_FAIL = 1;
  localparam int ST_RANGE_ERR = 2;
  localparam int ST_QUEUE_MISSING = 3;
  localparam int EV_QUEUE_LSB = 16;
  // reset value and bus response codes
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // engine states
  typedef enum logic [3:0] {
    S_IDLE, S_CFG_WR, S_CFG_RD, S_Q_SEL, S_Q_SIZE_RD, S_Q_SIZE_WR,
    S_Q_ADDR, S_Q_VEC_WR, S_Q_VEC_RD, S_NOTIFY, S_CAUSE_RD
  } qni_state_t;
endpackage : qni_pkg

// [design/qni_ctrl.sv]
// host-side controller: maps vectors, configures queues, rings doorbells, services interrupts
// assumes a device register port on aclk and an asynchronous legacy interrupt line
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - accept any table size up to 0x7ff
// - table size zero may use legacy line
// - refuse vectors beyond advertised table size
// - read mapping back, compare with written value
// - report failed mapping to software for decision
// - select queue, read size, zero means missing
// - optionally write smaller queue size back
// - software zeroes rings before enabling queue
// - queue address written divided by 4096
// - plain doorbell carries 16-bit queue index
// - extended doorbell packs queue, offset, wrap
// - one interrupt may carry both events
// - legacy: bit0 scans queues, bit1 config
// - message: scan mapped queues, match config vector
module qni_ctrl #(
  parameter int NQ = 8
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // device register port
  output logic dev_req,
  output logic dev_we,
  output logic [7:0] dev_addr,
  output logic [31:0] dev_wdata,
  input wire logic dev_ack,
  input wire logic [31:0] dev_rdata,
  // device interrupts
  input wire logic dev_line_irq,
  input wire logic dev_msg_valid,
  input wire logic [15:0] dev_msg_vector
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // vector is allowed when unmapped or within the table
  function automatic logic vec_ok(input logic [15:0] v, input logic [10:0] ts);
    return (v == qni_pkg::NO_VECTOR) || (v <= {5'h00, ts});
  endfunction : vec_ok

  // state
  qni_pkg::qni_state_t st_r, st_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [3:1] stat_r, stat_nxt;
  logic [15:0] qsize_r, qsize_nxt;
  logic [10:0] table_r, table_nxt;
  logic [15:0] vec_r, vec_nxt, cfgvec_r, cfgvec_nxt;
  logic [31:0] queue_r, queue_nxt, qaddr_r, qaddr_nxt;
  logic [15:0] bell_r, bell_nxt;
  logic [1:0] ev_r, ev_nxt;
  logic [NQ-1:0] evq_r, evq_nxt;
  logic [15:0] qvec_r [NQ], qvec_nxt [NQ];
  logic req_r, req_nxt, we_r, we_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic sync1_r, sync2_r;

  logic aw_got, w_got, do_wr, do_rd;
  logic [7:0] wa;
  logic [31:0] wd, rd_mux;
  logic [1:0] ev_set;
  logic [NQ-1:0] evq_set;

  always_comb begin
    st_nxt = st_r;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    cmd_nxt = cmd_r;
    stat_nxt = stat_r;
    qsize_nxt = qsize_r;
    table_nxt = table_r;
    vec_nxt = vec_r;
    cfgvec_nxt = cfgvec_r;
    queue_nxt = queue_r;
    qaddr_nxt = qaddr_r;
    bell_nxt = bell_r;
    qvec_nxt = qvec_r;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    ev_set = 2'h0;
    evq_set = '0;
    // write channel: address and data in either order
    aw_got = aw_hold_r || (s_axi_awvalid && !aw_hold_r && !bvalid_r);
    w_got = w_hold_r || (s_axi_wvalid && !w_hold_r && !bvalid_r);
    wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wd = w_hold_r ? w_data_r : s_axi_wdata;
    do_wr = aw_got && w_got && !bvalid_r;
    if (!aw_hold_r && s_axi_awvalid && !bvalid_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_hold_nxt = 1'b1;
    end
    if (!w_hold_r && s_axi_wvalid && !bvalid_r) begin
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
      w_hold_nxt = 1'b1;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    ev_nxt = ev_r;
    evq_nxt = evq_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = qni_pkg::RESP_OKAY;
      case (wa)
        qni_pkg::REG_CTRL: ctrl_nxt = 2'(merge({30'h0, ctrl_r}, wd, w_hold_r ? w_strb_r : s_axi_wstrb));
        qni_pkg::REG_CMD: cmd_nxt = cmd_r | wd[2:0];
        qni_pkg::REG_TABLE: table_nxt = 11'(merge({21'h0, table_r}, wd, w_hold_r ? w_strb_r : s_axi_wstrb));
        qni_pkg::REG_VEC: vec_nxt = 16'(merge({16'h0, vec_r}, wd, w_hold_r ? w_strb_r : s_axi_wstrb));
        qni_pkg::REG_QUEUE: queue_nxt = merge(queue_r, wd, w_hold_r ? w_strb_r : s_axi_wstrb);
        qni_pkg::REG_QADDR: qaddr_nxt = merge(qaddr_r, wd, w_hold_r ? w_strb_r : s_axi_wstrb);
        qni_pkg::REG_DOORBELL: bell_nxt = 16'(merge({16'h0, bell_r}, wd, w_hold_r ? w_strb_r : s_axi_wstrb));
        qni_pkg::REG_EVENTS: begin
          ev_nxt = ev_r & ~wd[1:0];
          evq_nxt = evq_r & ~wd[qni_pkg::EV_QUEUE_LSB +: NQ];
        end
        qni_pkg::REG_STATUS, qni_pkg::REG_CFGVEC: bresp_nxt = qni_pkg::RESP_OKAY;
        default: bresp_nxt = qni_pkg::RESP_SLVERR;
      endcase
    end
    // read channel
    rd_mux = qni_pkg::RST_ZERO;
    do_rd = s_axi_arvalid && !rvalid_r;
    case (s_axi_araddr)
      qni_pkg::REG_CTRL: rd_mux = {30'h0, ctrl_r};
      qni_pkg::REG_STATUS: rd_mux = {qsize_r, 12'h000, stat_r, st_r != qni_pkg::S_IDLE};
      qni_pkg::REG_TABLE: rd_mux = {21'h0, table_r};
      qni_pkg::REG_VEC: rd_mux = {16'h0, vec_r};
      qni_pkg::REG_QUEUE: rd_mux = queue_r;
      qni_pkg::REG_QADDR: rd_mux = qaddr_r;
      qni_pkg::REG_DOORBELL: rd_mux = {16'h0, bell_r};
      qni_pkg::REG_EVENTS: rd_mux = 32'({evq_r, 14'h0, ev_r});
      qni_pkg::REG_CFGVEC: rd_mux = {16'h0, cfgvec_r};
      default: rd_mux = qni_pkg::RST_ZERO;
    endcase
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (do_rd) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_mux;
      rresp_nxt = (s_axi_araddr <= qni_pkg::REG_CFGVEC && s_axi_araddr[1:0] == 2'h0)
                  ? qni_pkg::RESP_OKAY : qni_pkg::RESP_SLVERR;
    end
    // message events, matched against the mapped vectors
    if (dev_msg_valid && ctrl_r[qni_pkg::CTRL_MSG_EN] && dev_msg_vector != qni_pkg::NO_VECTOR) begin
      for (int q = 0; q < NQ; q++) begin
        if (qvec_r[q] == dev_msg_vector) begin
          evq_set[q] = 1'b1;
        end
      end
      ev_set[qni_pkg::CAUSE_USED] = |evq_set;
      ev_set[qni_pkg::CAUSE_CFG] = (dev_msg_vector == cfgvec_r);
    end
    // device access engine
    if (st_r == qni_pkg::S_IDLE) begin
      req_nxt = 1'b0;
      if (sync2_r && !ctrl_r[qni_pkg::CTRL_MSG_EN]) begin
        st_nxt = qni_pkg::S_CAUSE_RD;
        req_nxt = 1'b1;
        we_nxt = 1'b0;
        addr_nxt = qni_pkg::DEV_CAUSE;
      end else if (cmd_r[qni_pkg::CMD_MAP_CFG]) begin
        cmd_nxt[qni_pkg::CMD_MAP_CFG] = 1'b0;
        stat_nxt = 3'h0;
        if (vec_ok(vec_r, table_r)) begin
          st_nxt = qni_pkg::S_CFG_WR;
          req_nxt = 1'b1;
          we_nxt = 1'b1;
          addr_nxt = qni_pkg::DEV_CFG_VEC;
          wd_nxt = {16'h0, vec_r};
        end else begin
          stat_nxt[qni_pkg::ST_RANGE_ERR] = 1'b1;
        end
      end else if (cmd_r[qni_pkg::CMD_QUEUE_CFG]) begin
        cmd_nxt[qni_pkg::CMD_QUEUE_CFG] = 1'b0;
        stat_nxt = 3'h0;
        if (!ctrl_r[qni_pkg::CTRL_MSG_EN] || vec_ok(vec_r, table_r)) begin
          st_nxt = qni_pkg::S_Q_SEL;
          req_nxt = 1'b1;
          we_nxt = 1'b1;
          addr_nxt = qni_pkg::DEV_QUEUE_SEL;
          wd_nxt = {16'h0, queue_r[15:0]};
        end else begin
          stat_nxt[qni_pkg::ST_RANGE_ERR] = 1'b1;
        end
      end else if (cmd_r[qni_pkg::CMD_NOTIFY]) begin
        cmd_nxt[qni_pkg::CMD_NOTIFY] = 1'b0;
        st_nxt = qni_pkg::S_NOTIFY;
        req_nxt = 1'b1;
        we_nxt = 1'b1;
        addr_nxt = qni_pkg::DEV_QUEUE_NOTIFY;
        wd_nxt = ctrl_r[qni_pkg::CTRL_NOTIF_DATA] ? {bell_r, queue_r[15:0]}
                                                  : {16'h0, queue_r[15:0]};
      end
    end else if (dev_ack) begin
      st_nxt = qni_pkg::S_IDLE;
      req_nxt = 1'b0;
      case (st_r)
        qni_pkg::S_CFG_WR: begin
          st_nxt = qni_pkg::S_CFG_RD;
          req_nxt = 1'b1;
          we_nxt = 1'b0;
        end
        qni_pkg::S_CFG_RD: begin
          cfgvec_nxt = dev_rdata[15:0];
          stat_nxt[qni_pkg::ST_MAP_FAIL] = (dev_rdata[15:0] != vec_r);
        end
        qni_pkg::S_Q_SEL: begin
          st_nxt = qni_pkg::S_Q_SIZE_RD;
          req_nxt = 1'b1;
          we_nxt = 1'b0;
          addr_nxt = qni_pkg::DEV_QUEUE_SIZE;
        end
        qni_pkg::S_Q_SIZE_RD: begin
          qsize_nxt = dev_rdata[15:0];
          if (dev_rdata[15:0] == 16'h0000) begin
            stat_nxt[qni_pkg::ST_QUEUE_MISSING] = 1'b1;
          end else if (queue_r[31:16] != 16'h0000 && queue_r[31:16] < dev_rdata[15:0]) begin
            st_nxt = qni_pkg::S_Q_SIZE_WR;
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            wd_nxt = {16'h0, queue_r[31:16]};
            qsize_nxt = queue_r[31:16];
          end else begin
            st_nxt = qni_pkg::S_Q_ADDR;
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            addr_nxt = qni_pkg::DEV_QUEUE_ADDR;
            wd_nxt = qaddr_r >> qni_pkg::QADDR_SHIFT;
          end
        end
        qni_pkg::S_Q_SIZE_WR: begin
          st_nxt = qni_pkg::S_Q_ADDR;
          req_nxt = 1'b1;
          addr_nxt = qni_pkg::DEV_QUEUE_ADDR;
          wd_nxt = qaddr_r >> qni_pkg::QADDR_SHIFT;
        end
        qni_pkg::S_Q_ADDR: begin
          if (ctrl_r[qni_pkg::CTRL_MSG_EN]) begin
            st_nxt = qni_pkg::S_Q_VEC_WR;
            req_nxt = 1'b1;
            addr_nxt = qni_pkg::DEV_QUEUE_VEC;
            wd_nxt = {16'h0, vec_r};
          end
        end
        qni_pkg::S_Q_VEC_WR: begin
          st_nxt = qni_pkg::S_Q_VEC_RD;
          req_nxt = 1'b1;
          we_nxt = 1'b0;
        end
        qni_pkg::S_Q_VEC_RD: begin
          stat_nxt[qni_pkg::ST_MAP_FAIL] = (dev_rdata[15:0] != vec_r);
          for (int q = 0; q < NQ; q++) begin
            if (queue_r[15:0] == 16'(q)) begin
              qvec_nxt[q] = dev_rdata[15:0];
            end
          end
        end
        qni_pkg::S_CAUSE_RD: begin
          ev_set = ev_set | dev_rdata[1:0];
        end
        default: st_nxt = qni_pkg::S_IDLE;
      endcase
    end
    // a command written while the engine takes the same bit is kept
    if (do_wr && wa == qni_pkg::REG_CMD) begin
      cmd_nxt = cmd_nxt | wd[2:0];
    end
    // sets win over software clears
    ev_nxt = ev_nxt | ev_set;
    evq_nxt = evq_nxt | evq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= qni_pkg::S_IDLE;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= qni_pkg::RST_ZERO;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= qni_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= qni_pkg::RESP_OKAY;
      rdata_r <= qni_pkg::RST_ZERO;
      ctrl_r <= 2'h0;
      cmd_r <= 3'h0;
      stat_r <= 3'h0;
      qsize_r <= 16'h0000;
      table_r <= qni_pkg::TABLE_SIZE_MAX;
      vec_r <= qni_pkg::NO_VECTOR;
      cfgvec_r <= qni_pkg::NO_VECTOR;
      queue_r <= qni_pkg::RST_ZERO;
      qaddr_r <= qni_pkg::RST_ZERO;
      bell_r <= 16'h0000;
      ev_r <= 2'h0;
      evq_r <= '0;
      for (int q = 0; q < NQ; q++) begin
        qvec_r[q] <= qni_pkg::NO_VECTOR;
      end
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wd_r <= qni_pkg::RST_ZERO;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      cmd_r <= cmd_nxt;
      stat_r <= stat_nxt;
      qsize_r <= qsize_nxt;
      table_r <= table_nxt;
      vec_r <= vec_nxt;
      cfgvec_r <= cfgvec_nxt;
      queue_r <= queue_nxt;
      qaddr_r <= qaddr_nxt;
      bell_r <= bell_nxt;
      ev_r <= ev_nxt;
      evq_r <= evq_nxt;
      qvec_r <= qvec_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      sync1_r <= dev_line_irq;
      sync2_r <= sync1_r;
    end
  end

  // outputs
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign dev_req = req_r;
  assign dev_we = we_r;
  assign dev_addr = addr_r;
  assign dev_wdata = wd_r;

endmodule : qni_ctrl

`default_nettype wire

// [test/qni_ctrl_asserts.sv]
// checker for the controller's bus and device-port timing
// assumes binding to qni_ctrl, one clock aclk, reset aresetn
`timescale 1ns/10ps
`default_nettype none
module qni_ctrl_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // device port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [7:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic dev_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // device write completing at an offset
  sequence wr_done(a);
    ce && dev_req && dev_we && dev_ack && dev_addr == a;
  endsequence
  // device read of an offset
  sequence rd_next(a);
    dev_req && !dev_we && dev_addr == a;
  endsequence
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_ar_answer: assert property (ce && s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_req_holds: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_addr)
    && $stable(dev_we) && $stable(dev_wdata)) else $error("device request changed early");
  chk_cfg_readback: assert property (wr_done(8'h14) |=> rd_next(8'h14))
    else $error("config vector not read back");
  chk_qvec_readback: assert property (wr_done(8'h16) |=> rd_next(8'h16))
    else $error("queue vector not read back");
  chk_size_after_sel: assert property (wr_done(8'h0e) |=> rd_next(8'h0c))
    else $error("queue size not read after select");
  chk_bad_write: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr > 8'h24 |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  chk_bad_read: assert property (ce && s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h24
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule : qni_ctrl_asserts
`default_nettype wire

// [test/qni_dev_model.sv]
// device model: legacy register port, cause register, vector mapping, events
// assumes the bench commands events, failed mappings and answer delay
`timescale 1ns/10ps
`default_nettype none
module qni_dev_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [7:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  output logic dev_ack,
  output logic [31:0] dev_rdata,
  // interrupts
  output logic dev_line_irq,
  output logic dev_msg_valid,
  output logic [15:0] dev_msg_vector,
  // scenario controls
  input wire logic msg_en,
  input wire logic fail_map,
  input wire logic ev_used,
  input wire logic ev_cfg,
  input wire logic [1:0] ev_q,
  input wire logic [1:0] slow
);
  logic [15:0] sel_r, size_r, cfgvec_r;
  logic [15:0] qvec_r [4];
  logic [31:0] qaddr_r, notify_r, rd_r;
  logic [1:0] cause_r, wait_r;
  assign dev_line_irq = |cause_r;
  assign dev_rdata = dev_ack ? rd_r : ~rd_r;
  always_ff @(posedge aclk) begin
    dev_ack <= 1'b0;
    dev_msg_valid <= 1'b0;
    if (!aresetn) begin
      cfgvec_r <= 16'hffff;
      qvec_r <= '{default: 16'hffff};
      cause_r <= 2'h0;
      wait_r <= 2'h0;
      rd_r <= 32'h0;
      sel_r <= 16'h0;
      size_r <= 16'h0;
      qaddr_r <= 32'h0;
      notify_r <= 32'h0;
      dev_msg_vector <= 16'h0;
    end else begin
      if (!msg_en) begin
        cause_r <= cause_r | {ev_cfg, ev_used};
      end else if (ev_used && qvec_r[ev_q] != 16'hffff) begin
        dev_msg_valid <= 1'b1;
        dev_msg_vector <= qvec_r[ev_q];
      end else if (ev_cfg && cfgvec_r != 16'hffff) begin
        dev_msg_valid <= 1'b1;
        dev_msg_vector <= cfgvec_r;
      end
      if (dev_req && !dev_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == slow) begin
          wait_r <= 2'h0;
          dev_ack <= 1'b1;
          rd_r <= 32'h0;
          case (dev_addr)
            8'h08: qaddr_r <= dev_wdata;
            8'h0c: begin
              if (dev_we) size_r <= dev_wdata[15:0];
              else rd_r <= (sel_r < 16'h3) ? 32'h100 : 32'h0;
            end
            8'h0e: sel_r <= dev_wdata[15:0];
            8'h10: notify_r <= dev_wdata;
            8'h13: begin
              rd_r <= {30'h0, cause_r};
              cause_r <= 2'h0;
            end
            8'h14: begin
              if (dev_we) cfgvec_r <= fail_map ? 16'hffff : dev_wdata[15:0];
              else rd_r <= {16'h0, cfgvec_r};
            end
            8'h16: begin
              if (dev_we) qvec_r[sel_r[1:0]] <= fail_map ? 16'hffff : dev_wdata[15:0];
              else rd_r <= {16'h0, qvec_r[sel_r[1:0]]};
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : qni_dev_model
`default_nettype wire

// [test/qni_ctrl_bench.sv]
// testbench: drives the controller over axi4-lite against the device model
// assumes qni_dev_model on the device port and the checker bound below
`timescale 1ns/10ps
`default_nettype none
module qni_ctrl_bench;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, dev_wdata, dev_rdata, rd;
  logic dev_req, dev_we, dev_ack, dev_line_irq, dev_msg_valid;
  logic [7:0] dev_addr;
  logic [15:0] dev_msg_vector;
  logic msg_en = 1'b0, fail_map = 1'b0, ev_used = 1'b0, ev_cfg = 1'b0;
  logic [1:0] ev_q = 2'h0, slow = 2'h0;
  int n_errors = 0, checked = 0;
  qni_ctrl u_qni_ctrl (.*);
  qni_dev_model u_dev (.*);
  always #20 aclk = ~aclk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 60) begin
      n_errors++;
      $display("BAD t=%0t wait ran out", $time);
      end_of_test();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask : wr
  task automatic rdd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask : rdd
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic nz);
    int n;
    n = 0;
    do begin
      rdd(a);
      n++;
    end while ((|(rd & m)) !== nz && n < 60);
    tmo(n);
  endtask : poll
  task automatic run(input logic [31:0] c);
    wr(8'h04, c);
    poll(8'h08, 32'h1, 1'b0);
  endtask : run
  task automatic ev(input logic u, input logic c, input logic [1:0] q);
    @(posedge aclk);
    ev_used <= u;
    ev_cfg <= c;
    ev_q <= q;
    @(posedge aclk);
    ev_used <= 1'b0;
    ev_cfg <= 1'b0;
  endtask : ev
  task automatic t_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdd(8'h0c);
    chk(rd, 32'h7ff);
    rdd(8'h10);
    chk(rd, 32'hffff);
    rdd(8'h24);
    chk(rd, 32'hffff);
    chk({16'h0, u_dev.qvec_r[1]}, 32'hffff);
    rdd(8'h40);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h40, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_map;
    slow <= 2'h2;
    wr(8'h10, 32'h5);
    run(32'h1);
    chk(rd & 32'h2, 32'h0);
    rdd(8'h24);
    chk(rd, 32'h5);
    fail_map <= 1'b1;
    wr(8'h10, 32'h6);
    run(32'h1);
    chk(rd & 32'h2, 32'h2);
    rdd(8'h24);
    chk(rd, 32'hffff);
    fail_map <= 1'b0;
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h4);
    run(32'h1);
    chk(rd & 32'h4, 32'h4);
    chk({16'h0, u_dev.cfgvec_r}, 32'hffff);
    wr(8'h10, 32'h3);
    run(32'h1);
    rdd(8'h24);
    chk(rd, 32'h3);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h1);
    run(32'h1);
    chk(rd & 32'h4, 32'h4);
    chk({16'h0, u_dev.cfgvec_r}, 32'h3);
    wr(8'h0c, 32'h7ff);
    $display("t_map done");
  endtask : t_map
  task automatic t_queue;
    msg_en <= 1'b1;
    slow <= 2'h3;
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h0040_0001);
    wr(8'h18, 32'h0012_3000);
    wr(8'h10, 32'h2);
    run(32'h2);
    chk(rd, 32'h0040_0000);
    chk({16'h0, u_dev.size_r}, 32'h40);
    chk(u_dev.qaddr_r, 32'h123);
    chk({16'h0, u_dev.qvec_r[1]}, 32'h2);
    wr(8'h14, 32'h5);
    run(32'h2);
    chk(rd & 32'h8, 32'h8);
    chk({16'h0, u_dev.sel_r}, 32'h5);
    $display("t_queue done");
  endtask : t_queue
  task automatic t_notify;
    msg_en <= 1'b0;
    slow <= 2'h0;
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h2);
    run(32'h4);
    chk(u_dev.notify_r, 32'h2);
    wr(8'h00, 32'h2);
    wr(8'h1c, 32'h8005);
    run(32'h4);
    chk(u_dev.notify_r, 32'h8005_0002);
    $display("t_notify done");
  endtask : t_notify
  task automatic t_legacy;
    for (int i = 1; i < 4; i++) begin
      ev(i[0], i[1], 2'h1);
      poll(8'h20, 32'hffff_ffff, 1'b1);
      chk(rd, 32'(i));
      chk({30'h0, u_dev.cause_r}, 32'h0);
      wr(8'h20, 32'hffff_ffff);
    end
    $display("t_legacy done");
  endtask : t_legacy
  task automatic t_msg;
    msg_en <= 1'b1;
    wr(8'h00, 32'h1);
    ev(1'b1, 1'b0, 2'h1);
    poll(8'h20, 32'hffff_ffff, 1'b1);
    chk(rd, 32'h0002_0001);
    wr(8'h20, 32'hffff_ffff);
    ev(1'b0, 1'b1, 2'h0);
    poll(8'h20, 32'hffff_ffff, 1'b1);
    chk(rd, 32'h2);
    wr(8'h20, 32'hffff_ffff);
    ev(1'b1, 1'b0, 2'h3);
    rdd(8'h20);
    chk(rd, 32'h0);
    chk({30'h0, u_dev.cause_r}, 32'h0);
    wr(8'h10, 32'h2);
    run(32'h1);
    ev(1'b1, 1'b0, 2'h1);
    poll(8'h20, 32'hffff_ffff, 1'b1);
    chk(rd, 32'h0002_0003);
    $display("t_msg done");
  endtask : t_msg
  initial begin
    t_reset;
    t_map;
    t_queue;
    t_notify;
    t_legacy;
    t_msg;
    t_reset;
    end_of_test;
  end
endmodule : qni_ctrl_bench
bind qni_ctrl qni_ctrl_asserts u_chk (.*);
`default_nettype wire
